/* common/rct_pkg.sv */
// reset cause tracker: shared constants, register map and address decode
// assumes a 50 MHz core clock and 32-bit AXI4-Lite addressing
// Functional notes
// - track four reset sources in cause register
// - bit 3 set on external pin reset
// - writing 1 to bit 2 starts software reset
// - bit 1 set on watchdog timeout reset
// - bit 0 set on power-on reset
// - bits 7 to 4 always read zero
// - clear register write-only, ones clear cause bits
// - clear write keeping bit 2 reruns software reset
// - resets restore all but cause; POR resets watchdog
// - RAM valid except after serial download
// - after POR, RAM needs flag enabled and set
// - any reset maps program memory to zero
// - after reset run kernel, then vector zero
package rct_pkg;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned RST_HOLD_NS = 200;
    // least time, so round up
    localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CAUSE_W = 4;
    localparam int unsigned BIT_POR = 0;
    localparam int unsigned BIT_WDT = 1;
    localparam int unsigned BIT_SW = 2;
    localparam int unsigned BIT_EXT = 3;
    localparam logic [3:0] CAUSE_POR_VAL = 4'h1;
    localparam logic [3:0] IRQ_RST_VAL = 4'h0;
    localparam int unsigned LOW_VOLT_EN_BIT = 2;
    localparam int unsigned LOW_VOLT_FLAG_BIT = 3;
    localparam logic [31:0] BOOT_VECTOR = 32'h0000_0000;
    localparam logic [31:0] ADDR_CAUSE = 32'hFFFF_0230;
    localparam logic [31:0] ADDR_CLEAR = 32'hFFFF_0234;
    localparam logic [31:0] ADDR_IRQ_STAT = 32'hFFFF_0238;
    localparam logic [31:0] ADDR_IRQ_CLR = 32'hFFFF_023C;
    localparam logic [31:0] ADDR_IRQ_EN = 32'hFFFF_0240;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef logic [1:0] rct_kind_t;
    typedef enum logic [2:0] {
        REG_NONE, REG_CAUSE, REG_CLEAR, REG_IRQ_STAT, REG_IRQ_CLR, REG_IRQ_EN
    } rct_reg_e;
    // word-aligned decode shared by the read and the write path
    function automatic rct_reg_e rct_decode(input logic [31:0] a);
        rct_reg_e r;
        r = REG_NONE;
        case ({a[31:2], 2'b00})
            ADDR_CAUSE: r = REG_CAUSE;
            ADDR_CLEAR: r = REG_CLEAR;
            ADDR_IRQ_STAT: r = REG_IRQ_STAT;
            ADDR_IRQ_CLR: r = REG_IRQ_CLR;
            ADDR_IRQ_EN: r = REG_IRQ_EN;
            default: r = REG_NONE;
        endcase
        return r;
    endfunction
endpackage

/* common/rct_seq_if.sv */
// reset cause tracker: link between cause logic and the reset sequencer
// assumes both ends run on core_clk_i
interface rct_seq_if;
    import rct_pkg::*;
    logic req;
    rct_kind_t kind;
    logic active;
    logic done;
    rct_kind_t done_kind;
    modport ctrl (output req, output kind, input active, input done, input done_kind);
    modport seq (input req, input kind, output active, output done, output done_kind);
endinterface

/* src/rct_reset_seq.sv */
// reset cause tracker: stretches a reset request into a system reset pulse
// assumes requests are one-cycle or level, on core_clk_i
module rct_reset_seq
    import rct_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = RST_HOLD_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    rct_seq_if.seq seq
);
    localparam int unsigned CNT_W = $clog2(HOLD_CYCLES + 1);
    typedef enum logic {SEQ_HOLD, SEQ_IDLE} rct_seq_e;
    rct_seq_e state_reg;
    logic [CNT_W-1:0] cnt_reg;
    rct_kind_t kind_reg;
    logic done_reg;
    logic last;

    assign last = (cnt_reg == CNT_W'(HOLD_CYCLES - 1));

    // power-on starts in hold; a new request restarts the count, so a held pin stretches it
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_reg <= SEQ_HOLD;
            cnt_reg <= '0;
            kind_reg <= rct_kind_t'(BIT_POR);
        end else if (seq.req) begin
            state_reg <= SEQ_HOLD;
            cnt_reg <= '0;
            kind_reg <= seq.kind;
        end else begin
            unique case (state_reg)
                SEQ_HOLD: begin
                    cnt_reg <= cnt_reg + CNT_W'(1);
                    if (last) begin
                        state_reg <= SEQ_IDLE;
                    end
                end
                SEQ_IDLE: cnt_reg <= '0;
            endcase
        end
    end

    // one-cycle completion pulse carries the kind that ended
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= (state_reg == SEQ_HOLD) && last && !seq.req;
        end
    end

    assign seq.active = (state_reg == SEQ_HOLD);
    assign seq.done = done_reg;
    assign seq.done_kind = kind_reg;
endmodule // rct_reset_seq

/* src/rct_tracker.sv */
// reset cause tracker: cause register, AXI4-Lite slave, reset outputs
// assumes watchdog, download and high-voltage inputs are on core_clk_i;
// the reset pin is asynchronous; rst_n_i is the power-on reset
module rct_tracker
    import rct_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = RST_HOLD_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic ext_reset_n_i,
    input wire logic watchdog_timeout_i,
    input wire logic serial_download_i,
    input wire logic [7:0] high_voltage_config_zero_i,
    input wire logic [7:0] high_voltage_monitor_status_i,
    output logic sys_reset_o,
    output logic watchdog_reset_o,
    output logic remap_clear_o,
    output logic boot_start_o,
    output logic [31:0] boot_vector_o,
    output logic ram_valid_o,
    output logic irq_o
);
    rct_seq_if seq_if ();

    rct_reset_seq #(
        .HOLD_CYCLES(HOLD_CYCLES)
    ) u_seq (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .seq(seq_if.seq)
    );

    // reset pin synchroniser; level only moves when stages two and three agree
    logic ext_s1_reg;
    logic ext_s2_reg;
    logic ext_s3_reg;
    logic ext_lvl_reg;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ext_s1_reg <= 1'b1;
            ext_s2_reg <= 1'b1;
            ext_s3_reg <= 1'b1;
            ext_lvl_reg <= 1'b1;
        end else begin
            ext_s1_reg <= ext_reset_n_i;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
            if (ext_s2_reg == ext_s3_reg) begin
                ext_lvl_reg <= ext_s3_reg;
            end
        end
    end

    // write channel holding registers; address and data may arrive in either order
    logic aw_held_reg;
    logic w_held_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic [31:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic do_wr;
    rct_reg_e wr_sel;

    assign s_axi_awready_o = !aw_held_reg;
    assign s_axi_wready_o = !w_held_reg;
    assign do_wr = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_sel = rct_decode(awaddr_reg);

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
        end else if (s_axi_awvalid_i && !aw_held_reg) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr_i;
        end else if (do_wr) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            w_held_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (s_axi_wvalid_i && !w_held_reg) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata_i;
            wstrb_reg <= s_axi_wstrb_i;
        end else if (do_wr) begin
            w_held_reg <= 1'b0;
        end
    end

    // response follows the performed write; unmapped addresses get slverr
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready_i) begin
            bvalid_reg <= 1'b0;
        end
    end
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;

    // register writes only touch byte lane 0, where the 8-bit registers live
    logic [CAUSE_W-1:0] wb;
    logic cause_wr;
    logic clr_wr;
    logic irq_clr_wr;
    logic irq_en_wr;
    assign wb = wdata_reg[CAUSE_W-1:0];
    assign cause_wr = do_wr && wstrb_reg[0] && (wr_sel == REG_CAUSE);
    assign clr_wr = do_wr && wstrb_reg[0] && (wr_sel == REG_CLEAR);
    assign irq_clr_wr = do_wr && wstrb_reg[0] && (wr_sel == REG_IRQ_CLR);
    assign irq_en_wr = do_wr && wstrb_reg[0] && (wr_sel == REG_IRQ_EN);

    // reset requests from the pin and from software
    logic [CAUSE_W-1:0] cause_reg;
    logic [CAUSE_W-1:0] cause_next;
    logic ext_req;
    logic sw_req;
    assign ext_req = !ext_lvl_reg;
    assign sw_req = (cause_wr && wb[BIT_SW]) ||
                    (clr_wr && cause_reg[BIT_SW] && !wb[BIT_SW]);

    // set beats clear; only bit 2 is writable, the rest move by hardware
    always_comb begin
        cause_next = cause_reg & ~(clr_wr ? wb : '0);
        cause_next[BIT_EXT] = cause_next[BIT_EXT] | ext_req;
        cause_next[BIT_SW] = cause_next[BIT_SW] | sw_req;
        cause_next[BIT_WDT] = cause_next[BIT_WDT] | watchdog_timeout_i;
    end

    // the cause register survives every reset but power-on, which sets bit 0
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cause_reg <= CAUSE_POR_VAL;
        end else begin
            cause_reg <= cause_next;
        end
    end

    // pin reset outranks watchdog, which outranks software
    always_comb begin
        seq_if.req = ext_req || watchdog_timeout_i || sw_req;
        if (ext_req) begin
            seq_if.kind = rct_kind_t'(BIT_EXT);
        end else if (watchdog_timeout_i) begin
            seq_if.kind = rct_kind_t'(BIT_WDT);
        end else begin
            seq_if.kind = rct_kind_t'(BIT_SW);
        end
    end

    // interrupt registers are ordinary registers, so every reset kind clears them
    logic [CAUSE_W-1:0] irq_stat_reg;
    logic [CAUSE_W-1:0] irq_en_reg;
    logic [CAUSE_W-1:0] irq_set;
    assign irq_set = seq_if.done ? (CAUSE_W'(1) << seq_if.done_kind) : '0;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || seq_if.active) begin
            irq_stat_reg <= IRQ_RST_VAL;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~(irq_clr_wr ? wb : '0)) | irq_set;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || seq_if.active) begin
            irq_en_reg <= IRQ_RST_VAL;
        end else if (irq_en_wr) begin
            irq_en_reg <= wb;
        end
    end
    assign irq_o = |(irq_stat_reg & irq_en_reg);

    // read channel; write-only registers read as zero
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    rct_reg_e rd_sel;
    assign rd_sel = rct_decode(s_axi_araddr_i);
    assign s_axi_arready_o = !rvalid_reg;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (s_axi_arvalid_i && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= (rd_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            unique case (rd_sel)
                REG_CAUSE: rdata_reg <= {28'h000_0000, cause_reg};
                REG_IRQ_STAT: rdata_reg <= {28'h000_0000, irq_stat_reg};
                REG_IRQ_EN: rdata_reg <= {28'h000_0000, irq_en_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready_i) begin
            rvalid_reg <= 1'b0;
        end
    end
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;

    // every reset kind holds the system and unmaps RAM; only power-on hits the watchdog
    assign sys_reset_o = seq_if.active;
    assign remap_clear_o = seq_if.active;
    assign watchdog_reset_o = seq_if.active && (seq_if.done_kind == rct_kind_t'(BIT_POR));

    // kernel start follows the end of reset; vector is fixed at zero
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            boot_start_o <= 1'b0;
            boot_vector_o <= BOOT_VECTOR;
        end else begin
            boot_start_o <= seq_if.done;
            boot_vector_o <= BOOT_VECTOR;
        end
    end

    // a download marks RAM stale until the next reset has consumed the mark
    logic dl_pending_reg;
    logic flag_en;
    logic flag_ok;
    assign flag_en = high_voltage_config_zero_i[LOW_VOLT_EN_BIT];
    assign flag_ok = high_voltage_monitor_status_i[LOW_VOLT_FLAG_BIT];
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            dl_pending_reg <= 1'b0;
        end else if (serial_download_i) begin
            dl_pending_reg <= 1'b1;
        end else if (seq_if.done) begin
            dl_pending_reg <= 1'b0;
        end
    end

    // without the low-voltage flag a power-on can't vouch for RAM
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ram_valid_o <= 1'b0;
        end else if (seq_if.done) begin
            if (seq_if.done_kind == rct_kind_t'(BIT_POR)) begin
                ram_valid_o <= flag_en && flag_ok;
            end else begin
                ram_valid_o <= !dl_pending_reg;
            end
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_pin_sets_ext: assert property (ext_req |=> cause_reg[BIT_EXT] && sys_reset_o)
        else $error("pin reset did not set cause bit 3");
    chk_sw_write_reset: assert property (cause_wr && wb[BIT_SW] |=>
        cause_reg[BIT_SW] && sys_reset_o)
        else $error("software reset write not honoured");
    chk_wdt_sets_bit: assert property (watchdog_timeout_i |=> cause_reg[BIT_WDT])
        else $error("watchdog timeout did not set cause bit 1");
    chk_por_cause_bit: assert property ($rose(rst_n_i) |-> cause_reg == CAUSE_POR_VAL
        && watchdog_reset_o)
        else $error("power-on did not set cause bit 0");
    chk_upper_read_zero: assert property (s_axi_arvalid_i && !rvalid_reg
        && rd_sel == REG_CAUSE |=> s_axi_rdata_o[31:4] == 28'h000_0000)
        else $error("unused cause bits read nonzero");
    chk_clear_takes_bits: assert property (clr_wr && !ext_req && !watchdog_timeout_i |=>
        (cause_reg & $past(wb)) == '0)
        else $error("clear write left a cause bit set");
    chk_clear_rerun_sw: assert property (clr_wr && cause_reg[BIT_SW] && !wb[BIT_SW] |=>
        sys_reset_o && cause_reg[BIT_SW])
        else $error("clear keeping bit 2 did not rerun reset");
    chk_ram_after_dl: assert property (seq_if.done && dl_pending_reg
        && seq_if.done_kind != rct_kind_t'(BIT_POR) |=> !ram_valid_o)
        else $error("RAM marked valid after download");
    chk_boot_follows: assert property (seq_if.done && !seq_if.req |=> boot_start_o
        && boot_vector_o == BOOT_VECTOR && !sys_reset_o)
        else $error("kernel start did not follow reset");
    chk_cause_ro_bits: assert property (cause_wr && !wb[BIT_SW] && !ext_req
        && !watchdog_timeout_i |=> $stable(cause_reg))
        else $error("software write altered a hardware cause bit");

    cov_sw_reset: cover property (cause_wr && wb[BIT_SW] ##[1:40] boot_start_o);
    cov_pin_reset: cover property (ext_req ##[1:40] seq_if.done);
    cov_irq_raise: cover property (!irq_o ##1 irq_o);
    cov_unmapped: cover property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR);
endmodule // rct_tracker

/* tb/rct_src_model.sv */
// far-side model: reset pin, watchdog expiry, serial download and high-voltage levels
// assumes the bench calls its tasks from one process, all on core_clk_i
module rct_src_model (
    input wire logic core_clk_i,
    output logic ext_reset_n_o,
    output logic watchdog_timeout_o,
    output logic serial_download_o,
    output logic [7:0] high_voltage_config_zero_o,
    output logic [7:0] high_voltage_monitor_status_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // pin idles high; flag feature on and flag set, so ram starts intact
    initial begin
        ext_reset_n_o = 1'h1;
        watchdog_timeout_o = 1'h0;
        serial_download_o = 1'h0;
        high_voltage_config_zero_o = 8'h04;
        high_voltage_monitor_status_o = 8'h08;
    end

    // held low well past the pin filter, otherwise the press may be dropped
    task automatic pin_reset(input int cyc);
        @(posedge core_clk_i);
        ext_reset_n_o <= 1'h0;
        repeat (cyc) @(posedge core_clk_i);
        ext_reset_n_o <= 1'h1;
    endtask

    // expiry and download both arrive as single-cycle strobes
    task automatic pulse_wdog();
        @(posedge core_clk_i);
        watchdog_timeout_o <= 1'h1;
        @(posedge core_clk_i);
        watchdog_timeout_o <= 1'h0;
    endtask

    task automatic pulse_dl();
        @(posedge core_clk_i);
        serial_download_o <= 1'h1;
        @(posedge core_clk_i);
        serial_download_o <= 1'h0;
    endtask

    task automatic set_mon(input logic [7:0] m);
        @(posedge core_clk_i);
        high_voltage_monitor_status_o <= m;
    endtask
endmodule // rct_src_model

/* tb/tb_rct_tracker.sv */
// bench for the reset cause tracker: AXI4-Lite master tasks and reset scenarios
// assumes rct_src_model stands in for the reset sources; short hold count
module tb_rct_tracker
    import rct_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned HOLD = 2;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic [31:0] awaddr = 32'h0000_0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] araddr = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, ext_n, wdog, dl;
    logic sys_rst, wd_rst, remap, boot, ramv, irq;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, bvec, d;
    logic [7:0] cfg, mon;
    int error_cnt = 0;
    int comparisons = 0;
    int rst_cnt = 0;
    int boot_cnt = 0;
    logic sys_prev = 1'h0;
    logic later = 1'h0;
    logic rst_q = 1'h0;

    // reset as the design sampled it at the last edge
    always @(posedge core_clk) rst_q <= rst_n;

    rct_tracker #(.HOLD_CYCLES(HOLD)) rct_tracker_i (
        .core_clk_i(core_clk), .rst_n_i(rst_n),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .ext_reset_n_i(ext_n), .watchdog_timeout_i(wdog), .serial_download_i(dl),
        .high_voltage_config_zero_i(cfg), .high_voltage_monitor_status_i(mon),
        .sys_reset_o(sys_rst), .watchdog_reset_o(wd_rst), .remap_clear_o(remap),
        .boot_start_o(boot), .boot_vector_o(bvec), .ram_valid_o(ramv), .irq_o(irq)
    );

    rct_src_model rct_src_model_i (
        .core_clk_i(core_clk), .ext_reset_n_o(ext_n), .watchdog_timeout_o(wdog),
        .serial_download_o(dl), .high_voltage_config_zero_o(cfg),
        .high_voltage_monitor_status_o(mon)
    );

    // 50 MHz
    always #10 core_clk = ~core_clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // mid-cycle watch of the reset outputs, clear of edge races
    always @(negedge core_clk) begin
        if (sys_rst === 1'h1 && sys_prev !== 1'h1) rst_cnt++;
        if (boot === 1'h1) boot_cnt++;
        sys_prev = sys_rst;
        if (rst_q) chk(remap, sys_rst);
        else chk(wd_rst, 1'h1);
        if (sys_rst === 1'h1) chk(wd_rst, later ? 1'h0 : 1'h1);
    end

    // handshakes are judged on ready seen mid-cycle, released just after the edge
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] dv, output logic [1:0] rs);
        int n;
        logic awt, wt, bt;
        n = 0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= dv;
        wstrb <= 4'hF;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(negedge core_clk);
            awt = awvalid && awready;
            wt = wvalid && wready;
            bt = bvalid && bready;
            rs = bresp;
            @(posedge core_clk);
            if (awt) awvalid <= 1'h0;
            if (wt) wvalid <= 1'h0;
            if (bt) bready <= 1'h0;
            n++;
            if (n > 50) begin
                error_cnt++;
                final_report();
            end
        end while (!bt);
    endtask

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] dv, output logic [1:0] rs);
        int n;
        logic art, rt;
        n = 0;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(negedge core_clk);
            art = arvalid && arready;
            rt = rvalid && rready;
            dv = rdata;
            rs = rresp;
            @(posedge core_clk);
            if (art) arvalid <= 1'h0;
            if (rt) rready <= 1'h0;
            n++;
            if (n > 50) begin
                error_cnt++;
                final_report();
            end
        end while (!rt);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] dv);
        logic [1:0] rs;
        axi_wr(a, dv, rs);
        chk(rs, RESP_OKAY);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] dv;
        logic [1:0] rs;
        axi_rd(a, dv, rs);
        chk(dv, exp);
        chk(rs, RESP_OKAY);
    endtask

    // boot pulse count is the completion signal of every reset
    task automatic wait_boot(input int n);
        int k;
        for (k = 0; k < 300 && boot_cnt < n; k++) @(negedge core_clk);
        if (boot_cnt < n) begin
            error_cnt++;
            final_report();
        end
        @(negedge core_clk);
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'h1;
        wait_boot(1);
        chk(bvec, 32'h0000_0000);
        chk(ramv, 1'h1);
        rd_chk(ADDR_CAUSE, 32'h0000_0001);
        rd_chk(ADDR_CLEAR, 32'h0000_0000);
        later = 1'h1;
        wr(ADDR_CAUSE, 32'h0000_00FB);
        rd_chk(ADDR_CAUSE, 32'h0000_0001);
        wr(ADDR_CLEAR, 32'h0000_0001);
        rd_chk(ADDR_CAUSE, 32'h0000_0000);
        chk(rst_cnt, 32'h0000_0001);
        wr(ADDR_CAUSE, 32'h0000_0004);
        wait_boot(2);
        rd_chk(ADDR_CAUSE, 32'h0000_0004);
        // clear write leaving bit 2 alone must restart the software reset
        wr(ADDR_CLEAR, 32'h0000_00F0);
        wait_boot(3);
        chk(rst_cnt, 32'h0000_0003);
        rd_chk(ADDR_CAUSE, 32'h0000_0004);
        wr(ADDR_CLEAR, 32'h0000_0004);
        rd_chk(ADDR_CAUSE, 32'h0000_0000);
        chk(rst_cnt, 32'h0000_0003);
        rct_src_model_i.pulse_wdog();
        wait_boot(4);
        rd_chk(ADDR_CAUSE, 32'h0000_0002);
        chk(ramv, 1'h1);
        // interrupt raised, masked, unmasked and cleared
        rd_chk(ADDR_IRQ_STAT, 32'h0000_0002);
        chk(irq, 1'h0);
        wr(ADDR_IRQ_EN, 32'h0000_0002);
        chk(irq, 1'h1);
        wr(ADDR_IRQ_EN, 32'h0000_0000);
        chk(irq, 1'h0);
        wr(ADDR_IRQ_EN, 32'h0000_000F);
        chk(irq, 1'h1);
        wr(ADDR_IRQ_CLR, 32'h0000_0002);
        chk(irq, 1'h0);
        rd_chk(ADDR_IRQ_STAT, 32'h0000_0000);
        // download then pin reset: ram no longer trusted, cause bits accumulate
        rct_src_model_i.pulse_dl();
        rct_src_model_i.pin_reset(8);
        wait_boot(5);
        rd_chk(ADDR_CAUSE, 32'h0000_000A);
        chk(ramv, 1'h0);
        rd_chk(ADDR_IRQ_EN, 32'h0000_0000);
        axi_rd(32'hFFFF_0300, d, r);
        chk(r, RESP_SLVERR);
        axi_wr(32'hFFFF_0300, 32'h0000_00FF, r);
        chk(r, RESP_SLVERR);
        rd_chk(ADDR_CAUSE, 32'h0000_000A);
        // second power-on with the flag feature on but the flag low
        rct_src_model_i.set_mon(8'h00);
        later = 1'h0;
        @(posedge core_clk);
        rst_n <= 1'h0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'h1;
        wait_boot(6);
        rd_chk(ADDR_CAUSE, 32'h0000_0001);
        chk(ramv, 1'h0);
        chk(rst_cnt, 32'h0000_0006);
        final_report();
    end
endmodule // tb_rct_tracker
